// ---- hdl/trig_sync_pkg.sv ----
// Constants, enumerations and carriers for the transient trigger and sync block.
// Assumes a single 125 MHz clock and an Avalon-MM slave port with byte addressing.
//
// Function
// R1: Per-count option ALL redoes phase alignment every repetition; default aligns once.
// R2: Acquisition trigger source is at once, phase reference, bus trigger or trigger-out line.
// R3: At-once acquisition starts immediately; results flagged ready when calculations finish.
// R4: Phase-reference acquisition starts when phase A reaches the reference angle.
// R5: Trigger-out line source uses the same signal that drives the trigger output.
// R6: Immediate alignment (default) starts step, pulse or list output without waiting.
// R7: Angle-aligned start holds the output start until the programmed angle is reached.
// R8: Start angle accepted from -360 to +360 degrees, reset value zero.
// R9: Trigger state reads as idle, armed, busy or awaiting event.
// R10: State updates when the last list point executes, possibly before final dwell ends.
// R11: Host appends a very short final list point to hold busy to the end.
// R12: Cancel returns both trigger systems to idle at once, stopping all activity.
// R13: Initiate moves an idle system to awaiting event; ignored when not idle.
// R14: With both systems waiting, first event goes to acquisition, next to transient.
// R15: Auto re-arm returns the transient system to awaiting event; otherwise needs initiate.
// R16: Awaiting or armed goes busy on its condition; busy goes idle on completion.
package trig_sync_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int ANGLE_W = 10;
    localparam int TURN_W = 9;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_ANGLE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CMD = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;

    localparam int CTRL_PER_COUNT = 0;
    localparam int CTRL_ACQ_SRC = 1;
    localparam int CTRL_ALIGN = 3;
    localparam int CTRL_REARM = 4;
    localparam int CTRL_TRANS_SRC = 5;

    localparam int CMD_INIT_TRANS = 0;
    localparam int CMD_INIT_ACQ = 1;
    localparam int CMD_CANCEL = 2;
    localparam int CMD_BUS_TRIG = 3;

    localparam int STAT_TRANS = 0;
    localparam int STAT_ACQ = 2;
    localparam int STAT_READY = 4;

    localparam logic signed [ANGLE_W-1:0] ANGLE_MAX = 10'sh168;
    localparam logic signed [ANGLE_W-1:0] RST_ANGLE = 10'sh000;
    localparam logic RST_PER_COUNT_ALL = 1'b0;
    localparam logic RST_ANGLE_START = 1'b0;
    localparam logic RST_AUTO_REARM = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_AWAITING_EVENT = 2'h1,
        ST_ARMED = 2'h3,
        ST_BUSY = 2'h2
    } trig_state_e;

    typedef enum logic [1:0] {
        ACQ_AT_ONCE = 2'h0,
        ACQ_PHASE_REF = 2'h1,
        ACQ_BUS = 2'h2,
        ACQ_LOGIC_LEVEL_LINE = 2'h3
    } acq_src_e;

    typedef enum logic [1:0] {
        TSRC_AT_ONCE = 2'h0,
        TSRC_BUS = 2'h1,
        TSRC_EXT = 2'h2,
        TSRC_SPARE = 2'h3
    } trans_src_e;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } avs_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic waitrequest;
    } avs_rsp_s;

    // Folds a signed start angle into the 0..359 range of the phase reference.
    function automatic logic [TURN_W-1:0] to_turn(input logic signed [ANGLE_W-1:0] a);
        logic signed [ANGLE_W-1:0] t;
        t = a;
        if (a < 0) begin
            t = a + ANGLE_MAX;
        end else if (a == ANGLE_MAX) begin
            t = '0;
        end
        return t[TURN_W-1:0];
    endfunction

endpackage

// ---- hdl/transient_trigger_sync.sv ----
// Trigger state machines for the transient generator and the acquisition system,
// with phase-aligned start and an Avalon-MM register slave.
// Assumes all inputs are synchronous to I_CLOCK and handshake inputs are one-cycle pulses.
`timescale 1ns/1ns
module transient_trigger_sync import trig_sync_pkg::*; (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    // Register bus
    input wire avs_req_s I_AVS,
    output avs_rsp_s O_AVS,
    // Phase reference and trigger inputs
    input wire logic [TURN_W-1:0] I_PHASE_A_ANGLE,
    input wire logic I_BUS_TRIGGER,
    input wire logic I_EXT_TRIGGER,
    // Transient generator handshake
    input wire logic I_REPEAT_REQ,
    input wire logic I_LAST_POINT_DONE,
    output logic O_TRANSIENT_START,
    output logic O_CANCEL,
    // Acquisition handshake
    input wire logic I_ACQ_DONE,
    output logic O_ACQ_START,
    output logic O_RESULTS_READY
);

    typedef struct packed {
        logic per_count_all;
        acq_src_e acq_src;
        logic angle_start;
        logic auto_rearm;
        trans_src_e trans_src;
        logic signed [ANGLE_W-1:0] angle;
        trig_state_e tst;
        trig_state_e ast;
        logic results_ready;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic tstart;
        logic astart;
        logic cancel;
    } state_s;

    localparam state_s STATE_RST = '{
        per_count_all: RST_PER_COUNT_ALL,
        acq_src: ACQ_AT_ONCE,
        angle_start: RST_ANGLE_START,
        auto_rearm: RST_AUTO_REARM,
        trans_src: TSRC_AT_ONCE,
        angle: RST_ANGLE,
        tst: ST_IDLE,
        ast: ST_IDLE,
        default: '0
    };

    state_s s_r;
    state_s s_nxt;

    logic req;
    logic wr_take;
    logic cmd_wr;
    logic init_t;
    logic init_a;
    logic cancel_cmd;
    logic bus_ev;
    logic hit;
    logic acq_takes_bus;
    logic ev_t;
    logic acq_go;
    logic angle_ok;
    logic [DATA_W-1:0] rd_mux;

    assign req = I_AVS.read | I_AVS.write;
    // A write lands only on the edge where the master sees waitrequest low.
    assign wr_take = I_AVS.write & s_r.ack;
    assign cmd_wr = wr_take & (I_AVS.address == OFS_CMD) & I_AVS.byteenable[0];
    assign init_t = cmd_wr & I_AVS.writedata[CMD_INIT_TRANS];
    assign init_a = cmd_wr & I_AVS.writedata[CMD_INIT_ACQ];
    assign cancel_cmd = cmd_wr & I_AVS.writedata[CMD_CANCEL];
    assign bus_ev = I_BUS_TRIGGER | (cmd_wr & I_AVS.writedata[CMD_BUS_TRIG]);
    assign hit = (I_PHASE_A_ANGLE == to_turn(s_r.angle));
    // Acquisition outranks the transient system for a shared bus trigger.
    assign acq_takes_bus = (s_r.ast == ST_AWAITING_EVENT) & (s_r.acq_src == ACQ_BUS) & bus_ev; // R14

    always_comb begin
        unique case (s_r.trans_src)
            TSRC_BUS: ev_t = bus_ev & ~acq_takes_bus; // R14
            TSRC_EXT: ev_t = I_EXT_TRIGGER;
            default: ev_t = 1'b1;
        endcase
    end

    always_comb begin
        unique case (s_r.acq_src) // R2
            ACQ_AT_ONCE: acq_go = 1'b1; // R3
            ACQ_PHASE_REF: acq_go = hit; // R4
            ACQ_BUS: acq_go = bus_ev;
            ACQ_LOGIC_LEVEL_LINE: acq_go = s_r.tstart; // R5
        endcase
    end

    // Out-of-range angles are dropped whole; the upper word must be a clean sign extension.
    assign angle_ok = ((&I_AVS.writedata[DATA_W-1:ANGLE_W-1])
                       | ~(|I_AVS.writedata[DATA_W-1:ANGLE_W-1]))
                      & ($signed(I_AVS.writedata[ANGLE_W-1:0]) >= -ANGLE_MAX)
                      & ($signed(I_AVS.writedata[ANGLE_W-1:0]) <= ANGLE_MAX); // R8

    always_comb begin
        rd_mux = '0;
        unique case (I_AVS.address)
            OFS_CTRL: begin
                rd_mux[CTRL_PER_COUNT] = s_r.per_count_all;
                rd_mux[CTRL_ACQ_SRC+:2] = s_r.acq_src;
                rd_mux[CTRL_ALIGN] = s_r.angle_start;
                rd_mux[CTRL_REARM] = s_r.auto_rearm;
                rd_mux[CTRL_TRANS_SRC+:2] = s_r.trans_src;
            end
            OFS_ANGLE: rd_mux = DATA_W'(s_r.angle);
            OFS_STATUS: begin
                rd_mux[STAT_TRANS+:2] = s_r.tst; // R9
                rd_mux[STAT_ACQ+:2] = s_r.ast;
                rd_mux[STAT_READY] = s_r.results_ready;
            end
            default: rd_mux = '0;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.tstart = 1'b0;
        s_nxt.astart = 1'b0;
        s_nxt.cancel = 1'b0;
        s_nxt.ack = req & ~s_r.ack;
        if (req & ~s_r.ack) begin
            s_nxt.rdata = rd_mux;
        end
        if (wr_take && I_AVS.address == OFS_CTRL && I_AVS.byteenable[0]) begin
            s_nxt.per_count_all = I_AVS.writedata[CTRL_PER_COUNT];
            s_nxt.acq_src = acq_src_e'(I_AVS.writedata[CTRL_ACQ_SRC+:2]);
            s_nxt.angle_start = I_AVS.writedata[CTRL_ALIGN];
            s_nxt.auto_rearm = I_AVS.writedata[CTRL_REARM];
            s_nxt.trans_src = trans_src_e'(I_AVS.writedata[CTRL_TRANS_SRC+:2]);
        end
        if (wr_take && I_AVS.address == OFS_ANGLE && (&I_AVS.byteenable[1:0]) && angle_ok) begin
            s_nxt.angle = I_AVS.writedata[ANGLE_W-1:0]; // R8
        end

        unique case (s_r.tst)
            ST_IDLE: begin
                if (init_t) begin
                    s_nxt.tst = ST_AWAITING_EVENT; // R13
                end
            end
            ST_AWAITING_EVENT: begin
                if (ev_t) begin
                    if (s_r.angle_start) begin
                        s_nxt.tst = ST_ARMED; // R7
                    end else begin
                        s_nxt.tst = ST_BUSY; // R6 R16
                        s_nxt.tstart = 1'b1;
                    end
                end
            end
            ST_ARMED: begin
                if (hit) begin
                    s_nxt.tst = ST_BUSY; // R7 R16
                    s_nxt.tstart = 1'b1;
                end
            end
            ST_BUSY: begin
                if (I_LAST_POINT_DONE) begin
                    // Reported at the last point, so it may lead the final dwell.
                    s_nxt.tst = s_r.auto_rearm ? ST_AWAITING_EVENT : ST_IDLE; // R10 R15 R16
                end else if (I_REPEAT_REQ) begin
                    if (s_r.per_count_all && s_r.angle_start) begin
                        s_nxt.tst = ST_ARMED; // R1
                    end else begin
                        s_nxt.tstart = 1'b1; // R1
                    end
                end
            end
        endcase

        unique case (s_r.ast)
            ST_IDLE: begin
                if (init_a) begin
                    s_nxt.ast = ST_AWAITING_EVENT; // R13
                    s_nxt.results_ready = 1'b0;
                end
            end
            ST_AWAITING_EVENT: begin
                if (acq_go) begin
                    s_nxt.ast = ST_BUSY; // R16
                    s_nxt.astart = 1'b1;
                end
            end
            ST_ARMED, ST_BUSY: begin
                if (I_ACQ_DONE) begin
                    s_nxt.ast = ST_IDLE;
                    s_nxt.results_ready = 1'b1; // R3
                end
            end
        endcase

        if (cancel_cmd) begin
            s_nxt.tst = ST_IDLE; // R12
            s_nxt.ast = ST_IDLE;
            s_nxt.tstart = 1'b0;
            s_nxt.astart = 1'b0;
            s_nxt.cancel = 1'b1;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign O_AVS.readdata = s_r.rdata;
    assign O_AVS.waitrequest = req & ~s_r.ack;
    // The start pulse also drives the trigger output connector.
    assign O_TRANSIENT_START = s_r.tstart;
    assign O_CANCEL = s_r.cancel;
    assign O_ACQ_START = s_r.astart;
    assign O_RESULTS_READY = s_r.results_ready;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);

    sequence s_busy_step;
        s_r.tst == ST_BUSY && !cancel_cmd;
    endsequence

    sequence s_armed_wait;
        s_r.tst == ST_ARMED && !cancel_cmd;
    endsequence

    sequence s_acq_wait(acq_src_e src);
        s_r.ast == ST_AWAITING_EVENT && s_r.acq_src == src && !cancel_cmd;
    endsequence

    a_repeat_align: assert property ( // R1
        s_busy_step ##0 (I_REPEAT_REQ && !I_LAST_POINT_DONE) |=>
        ($past(s_r.per_count_all && s_r.angle_start) ?
         (s_r.tst == ST_ARMED && !O_TRANSIENT_START) : O_TRANSIENT_START))
        else $error("repetition start alignment wrong");
    a_bus_src_waits: assert property ( // R2
        s_acq_wait(ACQ_BUS) ##0 !bus_ev |=> s_r.ast == ST_AWAITING_EVENT && !O_ACQ_START)
        else $error("bus acquisition source started without event");
    a_acq_at_once: assert property ( // R3
        s_acq_wait(ACQ_AT_ONCE) |=> s_r.ast == ST_BUSY && O_ACQ_START ##1 !O_ACQ_START)
        else $error("at-once acquisition did not start");
    a_acq_phase_ref: assert property ( // R4
        s_acq_wait(ACQ_PHASE_REF) |=> O_ACQ_START == $past(hit))
        else $error("phase reference acquisition start mismatch");
    a_acq_line_src: assert property ( // R5
        s_acq_wait(ACQ_LOGIC_LEVEL_LINE) |=> O_ACQ_START == $past(O_TRANSIENT_START))
        else $error("trigger line acquisition not tied to trigger output");
    a_start_at_once: assert property ( // R6
        s_r.tst == ST_AWAITING_EVENT && ev_t && !s_r.angle_start && !cancel_cmd
        |=> s_r.tst == ST_BUSY && O_TRANSIENT_START)
        else $error("immediate transient start missing");
    a_start_aligned: assert property ( // R7
        s_armed_wait |=> O_TRANSIENT_START == $past(hit) && (s_r.tst == ST_BUSY) == $past(hit))
        else $error("aligned start not at reference angle");
    a_angle_range: assert property ( // R8
        s_r.angle >= -ANGLE_MAX && s_r.angle <= ANGLE_MAX)
        else $error("start angle out of range");
    a_state_read: assert property ( // R9
        I_AVS.read && !s_r.ack && I_AVS.address == OFS_STATUS
        |=> O_AVS.readdata[STAT_TRANS+:2] == $past(s_r.tst) && !O_AVS.waitrequest)
        else $error("status read does not show trigger state");
    a_last_point: assert property ( // R10
        s_busy_step ##0 (I_LAST_POINT_DONE && !s_r.auto_rearm) |=> s_r.tst == ST_IDLE)
        else $error("busy did not end at last point");
    a_cancel_all: assert property ( // R12
        cancel_cmd |=> s_r.tst == ST_IDLE && s_r.ast == ST_IDLE && O_CANCEL
        && !O_TRANSIENT_START && !O_ACQ_START)
        else $error("cancel did not idle both systems");
    a_init_idle: assert property ( // R13
        s_r.tst == ST_IDLE && init_t && !cancel_cmd |=> s_r.tst == ST_AWAITING_EVENT)
        else $error("initiate from idle ignored");
    a_init_ignored: assert property ( // R13
        s_armed_wait ##0 (init_t && !hit) |=> s_r.tst == ST_ARMED)
        else $error("initiate acted while not idle");
    a_acq_first: assert property ( // R14
        s_acq_wait(ACQ_BUS) ##0 (s_r.tst == ST_AWAITING_EVENT && s_r.trans_src == TSRC_BUS
        && bus_ev) |=> s_r.ast == ST_BUSY && s_r.tst == ST_AWAITING_EVENT)
        else $error("shared event not given to acquisition first");
    a_auto_rearm: assert property ( // R15
        s_busy_step ##0 (I_LAST_POINT_DONE && s_r.auto_rearm) |=> s_r.tst == ST_AWAITING_EVENT)
        else $error("auto re-arm did not return to awaiting");
    a_busy_holds: assert property ( // R16
        s_busy_step ##0 !I_LAST_POINT_DONE |=> s_r.tst inside {ST_BUSY, ST_ARMED})
        else $error("busy left without completion");

endmodule

// ---- verif/tts_partner.sv ----
// Behavioural model of the output generator and measurement engine beside the trigger block.
// Assumes one clock shared with the block and one-cycle start and cancel pulses from it.
`timescale 1ns/1ns
module tts_partner import trig_sync_pkg::*; (
    // Clock, reset and set-up
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [1:0] reps,
    // Pulses from the block
    input wire logic start,
    input wire logic acq_start,
    input wire logic cancel,
    // Answers to the block
    output logic [TURN_W-1:0] phase,
    output logic repeat_req,
    output logic last_done,
    output logic acq_done
);
    logic run;
    logic hold;
    logic [4:0] cnt;
    logic [1:0] left;
    logic [2:0] acnt;

    // Each list run dwells 21 cycles (count loaded with 20 down to 0); a pending repeat waits for the block to start it again.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= '0;
            {run, hold, cnt, left, acnt} <= '0;
            {repeat_req, last_done, acq_done} <= '0;
        end else begin
            phase <= (phase == 9'h167) ? 9'h000 : phase + 9'h001;
            repeat_req <= 1'h0;
            last_done <= 1'h0;
            acq_done <= (acnt == 3'h1);
            if (acnt != 3'h0) begin
                acnt <= acnt - 3'h1;
            end
            if (acq_start) begin
                acnt <= 3'h4;
            end
            if (start) begin
                run <= 1'h1;
                cnt <= 5'h14;
                hold <= 1'h0;
                if (!hold) begin
                    left <= reps;
                end
            end else if (run && cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end else if (run) begin
                run <= 1'h0;
                if (left != 2'h0) begin
                    repeat_req <= 1'h1;
                    left <= left - 2'h1;
                    hold <= 1'h1;
                end else begin
                    // The host closes each list with a one-cycle point, so this marks the true end.
                    last_done <= 1'h1;
                end
            end
            if (cancel) begin
                {run, hold, acnt} <= '0;
            end
        end
    end
endmodule

// ---- verif/test_transient_trigger_sync.sv ----
// Self-checking bench for the trigger block, driven over its Avalon-MM register port.
// Assumes the partner model supplies phase, list completion and acquisition completion.
`timescale 1ns/1ns
module test_transient_trigger_sync import trig_sync_pkg::*; ();
    logic clk, rst_b, bt, ext, rep_req, last_done, acq_done, ts, as_p, cn, rdy, prev_ts;
    logic [TURN_W-1:0] ph, prev_ph;
    logic [1:0] reps;
    logic [31:0] q;
    avs_req_s req;
    avs_rsp_s rsp;
    int n_errors = 0, num_checks = 0, n_ts = 0, n0;

    transient_trigger_sync DUT (.I_CLOCK(clk), .I_RST_B(rst_b), .I_AVS(req), .O_AVS(rsp),
        .I_PHASE_A_ANGLE(ph), .I_BUS_TRIGGER(bt), .I_EXT_TRIGGER(ext),
        .I_REPEAT_REQ(rep_req), .I_LAST_POINT_DONE(last_done), .O_TRANSIENT_START(ts),
        .O_CANCEL(cn), .I_ACQ_DONE(acq_done), .O_ACQ_START(as_p), .O_RESULTS_READY(rdy));
    tts_partner GEN (.clk(clk), .rst_b(rst_b), .reps(reps), .start(ts), .acq_start(as_p),
        .cancel(cn), .phase(ph), .repeat_req(rep_req), .last_done(last_done),
        .acq_done(acq_done));

    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Phase and start line as they stood in the cycle before the current one.
    always @(posedge clk) begin
        prev_ph <= ph;
        prev_ts <= ts;
        if (ts === 1'h1) n_ts <= n_ts + 1;
    end

    function automatic logic [31:0] stv(input trig_state_e t, input trig_state_e a,
                                        input logic r);
        return {27'h0, r, a, t};
    endfunction

    task automatic test_done;
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // Waitrequest is judged at each rising edge as the slave saw it; the request stands until
    // the edge that finds it low, where read data is taken and the request is dropped.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        req.address <= a;
        req.read <= ~w;
        req.write <= w;
        req.writedata <= d;
        req.byteenable <= 4'hF;
        do @(posedge clk); while (rsp.waitrequest !== 1'h0);
        q = rsp.readdata;
        req.read <= 1'h0;
        req.write <= 1'h0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic waitst(input logic [31:0] e);
        for (int k = 0; k < 100; k++) begin
            bus(1'h0, OFS_STATUS, 32'h0);
            if (q === e) break;
        end
        chk(q, e);
    endtask

    task automatic wait_ev(input int w);
        logic hit;
        hit = 1'h0;
        for (int k = 0; k < 1000 && !hit; k++) begin
            @(negedge clk);
            hit = (w == 0) ? ts === 1'h1 : (w == 1) ? as_p === 1'h1 : cn === 1'h1;
        end
        chk(32'(hit), 32'h1);
    endtask

    task automatic wait_ph(input logic [TURN_W-1:0] v);
        for (int k = 0; k < 400; k++) begin
            @(negedge clk);
            if (ph === v) break;
        end
    endtask

    task automatic pulse_bt;
        @(posedge clk);
        bt <= 1'h1;
        @(posedge clk);
        bt <= 1'h0;
    endtask

    task automatic t_reset;
        rd(OFS_CTRL, 32'h0);
        rd(OFS_ANGLE, 32'h0);
        rd(OFS_CMD, 32'h0);
        rd(OFS_STATUS, stv(ST_IDLE, ST_IDLE, 1'h0));
        rd(4'h2, 32'h0);
    endtask

    task automatic t_imm;
        n0 = n_ts;
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CMD, 32'h1);
        wait_ev(0);
        rd(OFS_STATUS, stv(ST_BUSY, ST_IDLE, 1'h0));
        wr(OFS_CMD, 32'h1);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h0));
        rd(OFS_STATUS, stv(ST_IDLE, ST_IDLE, 1'h0));
        chk(32'(n_ts - n0), 32'h1);
    endtask

    task automatic t_align;
        wr(OFS_ANGLE, 32'hFFFFFFA6);
        rd(OFS_ANGLE, 32'hFFFFFFA6);
        wr(OFS_ANGLE, 32'h169);
        rd(OFS_ANGLE, 32'hFFFFFFA6);
        reps <= 2'h1;
        wr(OFS_CTRL, 32'h9);
        wait_ph(9'h118);
        wr(OFS_CMD, 32'h1);
        rd(OFS_STATUS, stv(ST_ARMED, ST_IDLE, 1'h0));
        wr(OFS_CMD, 32'h1);
        rd(OFS_STATUS, stv(ST_ARMED, ST_IDLE, 1'h0));
        wait_ev(0);
        chk(32'(prev_ph), 32'h10E);
        wait_ev(0);
        chk(32'(prev_ph), 32'h10E);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h0));
        reps <= 2'h0;
        wr(OFS_ANGLE, 32'h168);
        wr(OFS_CTRL, 32'h8);
        wr(OFS_CMD, 32'h1);
        wait_ev(0);
        chk(32'(prev_ph), 32'h0);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h0));
    endtask

    task automatic t_acq;
        wr(OFS_ANGLE, 32'h5A);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CMD, 32'h2);
        wait_ev(1);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h1));
        chk(32'(rdy), 32'h1);
        wr(OFS_CTRL, 32'h2);
        wait_ph(9'h064);
        wr(OFS_CMD, 32'h2);
        rd(OFS_STATUS, stv(ST_IDLE, ST_AWAITING_EVENT, 1'h0));
        wait_ev(1);
        chk(32'(prev_ph), 32'h5A);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h1));
        n0 = n_ts;
        wr(OFS_CTRL, 32'h24);
        wr(OFS_CMD, 32'h3);
        rd(OFS_STATUS, stv(ST_AWAITING_EVENT, ST_AWAITING_EVENT, 1'h0));
        pulse_bt;
        wait_ev(1);
        waitst(stv(ST_AWAITING_EVENT, ST_IDLE, 1'h1));
        chk(32'(n_ts - n0), 32'h0);
        wr(OFS_CMD, 32'h8);
        wait_ev(0);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h1));
        wr(OFS_CTRL, 32'h6);
        wr(OFS_CMD, 32'h3);
        wait_ev(0);
        wait_ev(1);
        chk(32'(prev_ts), 32'h1);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h1));
    endtask

    // External source with aligned start and one repeat; the repeat must not wait for the angle.
    task automatic t_ext;
        reps <= 2'h1;
        wr(OFS_CTRL, 32'h48);
        wr(OFS_CMD, 32'h1);
        rd(OFS_STATUS, stv(ST_AWAITING_EVENT, ST_IDLE, 1'h1));
        @(posedge clk);
        ext <= 1'h1;
        @(posedge clk);
        ext <= 1'h0;
        wait_ev(0);
        chk(32'(prev_ph), 32'h5A);
        wait_ev(0);
        chk(32'(prev_ph), 32'h71);
        waitst(stv(ST_IDLE, ST_IDLE, 1'h1));
        reps <= 2'h0;
    endtask

    task automatic t_rearm;
        wr(OFS_CTRL, 32'h30);
        wr(OFS_CMD, 32'h1);
        pulse_bt;
        wait_ev(0);
        waitst(stv(ST_AWAITING_EVENT, ST_IDLE, 1'h1));
        pulse_bt;
        wait_ev(0);
        wr(OFS_CMD, 32'h4);
        wait_ev(2);
        rd(OFS_STATUS, stv(ST_IDLE, ST_IDLE, 1'h1));
    endtask

    initial begin
        req = '0;
        {bt, ext, reps} = '0;
        rst_b = 1'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        t_reset;
        t_imm;
        t_align;
        t_acq;
        t_ext;
        t_rearm;
        test_done;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        test_done;
    end
endmodule
